// ==== event_source.sv ====
// partner model: external event lines and the running local time
`default_nettype none
module event_source (
   input  wire logic   clk,
   output logic [1:0]  event_in,
   output logic [31:0] time_seconds,
   output logic [29:0] time_nanoseconds,
   output logic [2:0]  time_phase_slot
);
   timeunit 1ns;
   timeprecision 100ps;
   // quiet lines, time at zero
   initial begin
      event_in         = 2'h0;
      time_seconds     = 32'h0;
      time_nanoseconds = 30'h0;
      time_phase_slot  = 3'h0;
   end
   // toggle line u; the given time stands at the capture edge only
   task automatic fire(input int u, input logic [31:0] s, input logic [29:0] ns, input logic [2:0] ph);
      @(posedge clk);
      event_in[u]      <= ~event_in[u];
      time_seconds     <= s;
      time_nanoseconds <= ns;
      time_phase_slot  <= ph;
      @(posedge clk);
      // time moves on, so a late capture shows as a mismatch
      time_seconds     <= ~s;
      time_nanoseconds <= ~ns;
      time_phase_slot  <= ph + 3'h1;
   endtask : fire
endmodule : event_source
`default_nettype wire

// ==== event_timestamp_sample_capture.sv ====
// event timestamp input units: edge capture storage and avalon-mm register slave
//
// Chosen here: the Avalon-MM register port.
`default_nettype none

module event_timestamp_sample_capture
   import ts_capture_pkg::*;
#(
   parameter int NUM_UNITS = 2
) (
   input  wire logic                 clk,
   input  wire logic                 rst_b,
   // external events, one per unit, synchronous to clk
   input  wire logic [NUM_UNITS-1:0] event_in,
   // running time of the local clock
   input  wire logic [31:0]          time_seconds,
   input  wire logic [29:0]          time_nanoseconds,
   input  wire logic [2:0]           time_phase_slot,
   // avalon-mm slave
   input  wire logic [11:0]          address,
   input  wire logic                 read,
   input  wire logic                 write,
   input  wire logic [31:0]          writedata,
   input  wire logic [3:0]           byteenable,
   output logic [31:0]               readdata,
   output logic                      waitrequest
);

   // the pointer is one bit wide: one or two units only, refused at elaboration
   if (NUM_UNITS < 1 || NUM_UNITS > 2) begin : g_bad_units
      $error("NUM_UNITS must be 1 or 2");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed {
      logic                          rise_en;     // rising edge capture on
      logic                          fall_en;     // falling edge capture on
      logic [3:0]                    edge_cnt;    // detected edges, saturating
      logic                          overflow;    // more than 15 edges seen
      logic                          prev_in;     // event level last cycle
      sample_t [SAMPLES_KEPT-1:0]    smp;         // first three samples
   } unit_t;

   typedef struct packed {
      unit_t [NUM_UNITS-1:0] u;        // per-unit state
      logic                  unit_ptr; // selected unit for register access
      logic                  ack;      // bus answer in progress
      logic [31:0]           rdata;    // registered read data
   } state_t;

   state_t state_q;  // registered state
   state_t state_d;  // next state

   logic       sel_unit;     // unit index actually used
   logic       bus_go;       // request accepted this cycle
   logic [2:0] cur_phase;    // legal phase code for this cycle

   ////////////////////////////////////////////////////////////////////////////
   // phase slot to code; anything above the fifth slot is clamped
   function automatic logic [2:0] phase_code(input logic [2:0] slot);
      logic [2:0] code;
      code = PHASE_32NS;
      unique case (slot)
         3'h0: code = PHASE_0NS;
         3'h1: code = PHASE_8NS;
         3'h2: code = PHASE_16NS;
         3'h3: code = PHASE_24NS;
         default: code = PHASE_32NS;
      endcase
      return code;
   endfunction : phase_code

   // a sample read back in register form
   function automatic logic [31:0] ns_word(input sample_t s);
      ns_word = {1'b0, s.polarity, s.nanoseconds};
   endfunction : ns_word

   assign sel_unit = (NUM_UNITS > 1) ? state_q.unit_ptr : 1'b0;
   // the answer comes one cycle after the request is seen
   assign waitrequest = (read | write) & ~state_q.ack;
   assign bus_go      = (read | write) & state_q.ack;
   assign readdata    = state_q.rdata;

   assign cur_phase = phase_code(time_phase_slot);

   ////////////////////////////////////////////////////////////////////////////
   // next state: edge capture, register writes, read mux
   always_comb begin
      logic       rise;
      logic       fall;
      logic       hit;
      logic       restart;
      unit_t      cu;
      rise    = 1'b0;
      fall    = 1'b0;
      hit     = 1'b0;
      restart = 1'b0;
      cu      = state_q.u[sel_unit];
      state_d = state_q;
      // one-cycle answer; the ack drops once the request is served
      state_d.ack = (read | write) & ~state_q.ack;

      for (int i = 0; i < NUM_UNITS; i++) begin
         rise = event_in[i] & ~state_q.u[i].prev_in;
         fall = ~event_in[i] & state_q.u[i].prev_in;
         hit  = (rise & state_q.u[i].rise_en) | (fall & state_q.u[i].fall_en);
         // write one to the overflow bit restarts the unit
         restart = write & bus_go & (address == CAPTURE_CTRL_OFS) & byteenable[2]
                   & writedata[OVF_BIT] & (sel_unit == i[0]);
         state_d.u[i].prev_in = event_in[i];
         if (restart) begin
            state_d.u[i].edge_cnt = 4'h0;
            state_d.u[i].overflow = 1'b0;
         end
         if (hit) begin
            // an edge in the restart cycle wins: it becomes sample one
            if (restart) begin
               state_d.u[i].edge_cnt = 4'h1;
            end
            else if (state_q.u[i].edge_cnt == CNT_MAX) begin
               state_d.u[i].overflow = 1'b1;
            end else begin
               state_d.u[i].edge_cnt = state_q.u[i].edge_cnt + 4'h1;
            end
            for (int k = 0; k < SAMPLES_KEPT; k++) begin
               if ((restart && k == 0) || (!restart && state_q.u[i].edge_cnt == 4'(k))) begin
                  state_d.u[i].smp[k].seconds     = time_seconds;
                  state_d.u[i].smp[k].nanoseconds = time_nanoseconds;
                  state_d.u[i].smp[k].polarity    = rise;
                  state_d.u[i].smp[k].phase_slot  = cur_phase;
               end
            end
         end
      end

      // register writes take effect when the wait ends
      if (write && bus_go) begin
         if (address == UNIT_INDEX_OFS && byteenable[1]) begin
            state_d.unit_ptr = writedata[UNIT_PTR_BIT];
         end
         if (address == CAPTURE_CTRL_OFS && byteenable[0]) begin
            state_d.u[sel_unit].rise_en = writedata[RISE_EN_BIT];
            state_d.u[sel_unit].fall_en = writedata[FALL_EN_BIT];
         end
      end

      if (read && !state_q.ack) begin
         unique case (address)
            UNIT_INDEX_OFS:    state_d.rdata = 32'(state_q.unit_ptr) << UNIT_PTR_BIT;
            CAPTURE_CTRL_OFS:  state_d.rdata = (32'(cu.edge_cnt) << CNT_LSB)
                                             | (32'(cu.overflow) << OVF_BIT)
                                             | (32'(cu.rise_en) << RISE_EN_BIT)
                                             | (32'(cu.fall_en) << FALL_EN_BIT);
            SAMPLE1_NS_OFS:    state_d.rdata = ns_word(cu.smp[0]);
            SAMPLE1_SEC_OFS:   state_d.rdata = cu.smp[0].seconds;
            SAMPLE1_PHASE_OFS: state_d.rdata = 32'(cu.smp[0].phase_slot);
            SAMPLE2_NS_OFS:    state_d.rdata = ns_word(cu.smp[1]);
            SAMPLE2_SEC_OFS:   state_d.rdata = cu.smp[1].seconds;
            SAMPLE2_PHASE_OFS: state_d.rdata = 32'(cu.smp[1].phase_slot);
            SAMPLE3_NS_OFS:    state_d.rdata = ns_word(cu.smp[2]);
            SAMPLE3_SEC_OFS:   state_d.rdata = cu.smp[2].seconds;
            SAMPLE3_PHASE_OFS: state_d.rdata = 32'(cu.smp[2].phase_slot);
            // unmapped addresses read as zero
            default:           state_d.rdata = WORD_RESET;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register, synchronous active-low reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         // samples and control clear at reset
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   // bus request served: one wait cycle then done
   sequence seq_bus_served;
      (read | write) & waitrequest ##1 ~waitrequest;
   endsequence

   AST_BUS_ONE_WAIT: assert property ((read | write) & ~state_q.ack |-> seq_bus_served)
      else $error("bus answer not after one wait cycle");

   AST_READ_SELECTED: assert property (read & ~waitrequest & address == SAMPLE1_SEC_OFS & $stable(sel_unit)
                                       & $stable(state_q.u[sel_unit].smp[0].seconds)
                                       |-> readdata == state_q.u[sel_unit].smp[0].seconds)
      else $error("seconds read not from selected unit");

   AST_NS_LAYOUT: assert property (read & ~waitrequest & address == SAMPLE1_NS_OFS |-> readdata[31] == 1'b0)
      else $error("nanoseconds reserved bit set");

   // pointer write lands when the wait ends
   AST_PTR_WRITE: assert property (write & ~waitrequest & address == UNIT_INDEX_OFS & byteenable[1]
                                   |=> state_q.unit_ptr == $past(writedata[UNIT_PTR_BIT]))
      else $error("unit pointer write lost");

   generate
      for (genvar g = 0; g < NUM_UNITS; g++) begin : g_chk
         // an enabled rising edge seen with an empty unit
         sequence seq_first_rise;
            event_in[g] & ~state_q.u[g].prev_in & state_q.u[g].rise_en & state_q.u[g].edge_cnt == 4'h0
            & ~(write & bus_go & address == CAPTURE_CTRL_OFS);
         endsequence

         AST_FIRST_SECONDS: assert property (seq_first_rise |=> state_q.u[g].smp[0].seconds
                                              == $past(time_seconds))
            else $error("first sample seconds not captured");

         AST_FIRST_NS_POL: assert property (seq_first_rise |=> state_q.u[g].smp[0].nanoseconds
                                             == $past(time_nanoseconds) && state_q.u[g].smp[0].polarity)
            else $error("first sample nanoseconds or polarity wrong");

         AST_SLOT_24NS: assert property (seq_first_rise and time_phase_slot == 3'h3
                                          |=> state_q.u[g].smp[0].phase_slot == 3'h3)
            else $error("slot four not coded 011");

         AST_SLOT_16NS: assert property (seq_first_rise and time_phase_slot == 3'h2
                                          |=> state_q.u[g].smp[0].phase_slot == 3'h2)
            else $error("slot three not coded 010");

         AST_SLOT_0NS: assert property (seq_first_rise and time_phase_slot == 3'h0
                                         |=> state_q.u[g].smp[0].phase_slot == 3'h0)
            else $error("slot one not coded 000");

         AST_PHASE_LEGAL: assert property (state_q.u[g].smp[0].phase_slot <= 3'h4
                                            && state_q.u[g].smp[1].phase_slot <= 3'h4
                                            && state_q.u[g].smp[2].phase_slot <= 3'h4)
            else $error("reserved phase code stored");

         AST_OVF_SAT: assert property (state_q.u[g].edge_cnt == 4'hF & state_q.u[g].rise_en & event_in[g]
                                        & ~state_q.u[g].prev_in & ~(write & bus_go)
                                        |=> state_q.u[g].overflow && state_q.u[g].edge_cnt == 4'hF)
            else $error("count not saturated with overflow");

         // enabled rising edge below full count steps the count
         AST_CNT_STEP: assert property (state_q.u[g].edge_cnt != 4'hF & state_q.u[g].rise_en & event_in[g]
                                         & ~state_q.u[g].prev_in & ~(write & bus_go)
                                         |=> state_q.u[g].edge_cnt == $past(state_q.u[g].edge_cnt) + 4'h1)
            else $error("edge count did not step");

         AST_FIRST_FALL: assert property (~event_in[g] & state_q.u[g].prev_in & state_q.u[g].fall_en
                                           & state_q.u[g].edge_cnt == 4'h0 & ~(write & bus_go)
                                           |=> ~state_q.u[g].smp[0].polarity)
            else $error("falling edge not stored as zero");

         AST_DISABLED_IGNORED: assert property ((event_in[g] ^ state_q.u[g].prev_in) & ~state_q.u[g].rise_en
                                                 & ~state_q.u[g].fall_en & ~(write & bus_go)
                                                 |=> $stable(state_q.u[g].edge_cnt))
            else $error("disabled edge changed the count");

         // zero after reset; no past value needed at the first edge
         AST_RESET_ZERO: assert property (disable iff (1'b0) !rst_b |=> state_q.u[g].smp[0].seconds == 32'h0
                                           && state_q.u[g].edge_cnt == 4'h0)
            else $error("sample not zero after reset");
      end
   endgenerate

endmodule : event_timestamp_sample_capture

`default_nettype wire

// ==== event_timestamp_sample_capture_test.sv ====
// self-checking bench for the timestamp sample capture block
`default_nettype none
module event_timestamp_sample_capture_test import ts_capture_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0;
   logic        rst_b, read, write, waitrequest;
   logic [11:0] address;
   logic [31:0] writedata, readdata, rd;
   logic [3:0]  byteenable;
   logic [1:0]  event_in, lvl;
   logic [31:0] time_seconds, s[4];
   logic [29:0] time_nanoseconds, ns[4];
   logic [2:0]  time_phase_slot, ph[4];
   logic [3:0]  pol;
   int          err_count, samples_checked, seed;
   // 200 MHz clock
   always #2.5 clk = ~clk;
   event_source src (.clk(clk), .event_in(event_in), .time_seconds(time_seconds),
      .time_nanoseconds(time_nanoseconds), .time_phase_slot(time_phase_slot));
   event_timestamp_sample_capture #(.NUM_UNITS(2)) dut (.clk(clk), .rst_b(rst_b), .event_in(event_in),
      .time_seconds(time_seconds), .time_nanoseconds(time_nanoseconds), .time_phase_slot(time_phase_slot),
      .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
      .readdata(readdata), .waitrequest(waitrequest));
   ////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checked %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one avalon transfer; held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk);
      read      <= ~wr;
      write     <= wr;
      address   <= a;
      writedata <= wd;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 20);
      // a hung slave ends the run
      if (n >= 20) begin
         err_count++;
         $display("BAD %0t bus hang", $time);
         tally_and_finish();
      end
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rd_chk
   // one edge on line u, remembered as sample k
   task automatic ev(input int u, input int k, input logic [2:0] slot);
      s[k]  = $random(seed);
      ns[k] = 30'($random(seed));
      ph[k] = slot;
      lvl[u] = ~lvl[u];
      pol[k] = lvl[u];
      src.fire(u, s[k], ns[k], slot);
   endtask : ev
   // slots above the fifth clamp to its code
   function automatic logic [31:0] exp_phase(input logic [2:0] sl);
      return (sl > 3'h4) ? 32'h4 : {29'h0, sl};
   endfunction : exp_phase
   ////////////////////////////////////////////////////////////
   initial begin
      seed = 32'hF6E0F5AE;
      rst_b = 1'b0;
      read = 1'b0;
      write = 1'b0;
      address = 12'h0;
      writedata = 32'h0;
      byteenable = 4'hF;
      lvl = 2'h0;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      // reset values, unmapped words beyond sample 3 read zero
      for (int a = 0; a < 12; a++) rd_chk(SAMPLE1_NS_OFS + 12'(a * 4), WORD_RESET);
      $display("test reset done");
      // disabled edge on unit 1 is not counted
      ev(1, 0, 3'h1);
      bus(1'b1, UNIT_INDEX_OFS, 32'h0000_0100);
      rd_chk(UNIT_INDEX_OFS, 32'h0000_0100);
      rd_chk(CAPTURE_CTRL_OFS, 32'h0);
      // rising only: falling edge ignored, rising edge captured
      bus(1'b1, CAPTURE_CTRL_OFS, 32'h0000_0080);
      ev(1, 0, 3'h2);
      ev(1, 0, 3'h3);
      rd_chk(CAPTURE_CTRL_OFS, 32'h0002_0080);
      rd_chk(SAMPLE1_NS_OFS, {2'b01, ns[0]});
      rd_chk(SAMPLE1_SEC_OFS, s[0]);
      rd_chk(SAMPLE1_PHASE_OFS, 32'h0000_0003);
      $display("test pointer done");
      // unit 0: three rounds cover all eight slot inputs, polarities alternate
      bus(1'b1, UNIT_INDEX_OFS, 32'h0);
      for (int r = 0; r < 3; r++) begin
         bus(1'b1, CAPTURE_CTRL_OFS, 32'h0001_00C0);
         for (int k = 0; k < 3; k++) ev(0, k, 3'(r * 3 + k));
         for (int k = 0; k < 3; k++) begin
            rd_chk(SAMPLE1_NS_OFS + 12'(k * 12), {1'b0, pol[k], ns[k]});
            rd_chk(SAMPLE1_SEC_OFS + 12'(k * 12), s[k]);
            rd_chk(SAMPLE1_PHASE_OFS + 12'(k * 12), exp_phase(ph[k]));
         end
         rd_chk(CAPTURE_CTRL_OFS, 32'h0006_00C0);
      end
      $display("test samples done");
      // read-only sample ignores a write
      bus(1'b1, SAMPLE1_SEC_OFS, 32'hFFFF_FFFF);
      rd_chk(SAMPLE1_SEC_OFS, s[0]);
      // thirteen more edges: count saturates and overflow sets
      repeat (13) ev(0, 3, 3'($random(seed)));
      rd_chk(CAPTURE_CTRL_OFS, 32'h001F_00C0);
      rd_chk(SAMPLE3_SEC_OFS, s[2]);
      $display("test overflow done");
      // falling only on unit 1: falling edge captured, rising edge ignored
      bus(1'b1, UNIT_INDEX_OFS, 32'h0000_0100);
      bus(1'b1, CAPTURE_CTRL_OFS, 32'h0001_0040);
      ev(1, 0, 3'h4);
      ev(1, 1, 3'h0);
      rd_chk(CAPTURE_CTRL_OFS, 32'h0002_0040);
      rd_chk(SAMPLE1_NS_OFS, {2'b00, ns[0]});
      rd_chk(SAMPLE1_SEC_OFS, s[0]);
      rd_chk(SAMPLE1_PHASE_OFS, 32'h0000_0004);
      // pointer write with its lane off is ignored
      byteenable <= 4'h0;
      bus(1'b1, UNIT_INDEX_OFS, 32'h0);
      byteenable <= 4'hF;
      rd_chk(UNIT_INDEX_OFS, 32'h0000_0100);
      $display("test falling done");
      // second reset in mid-run clears pointer, samples and control
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(UNIT_INDEX_OFS, 32'h0);
      rd_chk(SAMPLE1_SEC_OFS, WORD_RESET);
      rd_chk(SAMPLE1_NS_OFS, WORD_RESET);
      rd_chk(CAPTURE_CTRL_OFS, 32'h0);
      $display("test second reset done");
      tally_and_finish();
   end
endmodule : event_timestamp_sample_capture_test
`default_nettype wire

// ==== ts_capture_pkg.sv ====
// constants, offsets and field layout of the event timestamp capture block
`default_nettype none

package ts_capture_pkg;
   // register byte offsets
   localparam logic [11:0] UNIT_INDEX_OFS     = 12'h540;
   localparam logic [11:0] CAPTURE_CTRL_OFS   = 12'h550;
   localparam logic [11:0] SAMPLE1_NS_OFS     = 12'h554;
   localparam logic [11:0] SAMPLE1_SEC_OFS    = 12'h558;
   localparam logic [11:0] SAMPLE1_PHASE_OFS  = 12'h55C;
   localparam logic [11:0] SAMPLE2_NS_OFS     = 12'h560;
   localparam logic [11:0] SAMPLE2_SEC_OFS    = 12'h564;
   localparam logic [11:0] SAMPLE2_PHASE_OFS  = 12'h568;
   localparam logic [11:0] SAMPLE3_NS_OFS     = 12'h56C;
   localparam logic [11:0] SAMPLE3_SEC_OFS    = 12'h570;
   localparam logic [11:0] SAMPLE3_PHASE_OFS  = 12'h574;
   // field positions
   localparam int UNIT_PTR_BIT   = 8;
   localparam int RISE_EN_BIT    = 7;
   localparam int FALL_EN_BIT    = 6;
   localparam int OVF_BIT        = 16;
   localparam int CNT_LSB        = 17;
   localparam int POLARITY_BIT   = 30;
   // capture counting
   localparam int          SAMPLES_KEPT = 3;
   localparam logic [3:0]  CNT_MAX      = 4'hF;
   // phase slot codes within the 40 ns period
   localparam logic [2:0]  PHASE_0NS    = 3'h0;
   localparam logic [2:0]  PHASE_8NS    = 3'h1;
   localparam logic [2:0]  PHASE_16NS   = 3'h2;
   localparam logic [2:0]  PHASE_24NS   = 3'h3;
   localparam logic [2:0]  PHASE_32NS   = 3'h4;
   // reset values
   localparam logic [31:0] WORD_RESET   = 32'h0000_0000;
   localparam logic [2:0]  PHASE_RESET  = 3'h0;

   // one stored sample
   typedef struct packed {
      logic [31:0] seconds;
      logic [29:0] nanoseconds;
      logic        polarity;
      logic [2:0]  phase_slot;
   } sample_t;
endpackage : ts_capture_pkg

`default_nettype wire
